// file: hdl/uls_sequencer.sv
`timescale 1ns/100ps
// Purpose: activation and deactivation sequencer for an LT or NT loop end
// Assumes: line events arrive synchronous to pclk, as one-cycle pulses except the levels rx_act, rx_dea and sig_present
// Notes:   line-side framing and tone detection sit outside this block
module uls_sequencer
	import uls_pkg::*;
#(
	parameter longint unsigned TIMEOUT_CYC = ACT_TIMEOUT_CYC,
	parameter longint unsigned RESYNC_LIM  = RESYNC_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	// line receiver events (one-cycle pulses) and levels rx_act, rx_dea, sig_present
	input  wire logic        wake_tone,
	input  wire logic        sf_sync,
	input  wire logic        sf_tick,
	input  wire logic        rx_act,
	input  wire logic        rx_dea,
	input  wire logic        sync_lost,
	input  wire logic        sig_present,
	// line transmitter controls
	output logic             tx_enable,
	output logic             tx_act,
	output logic             tx_dea,
	output logic             tx_cso,
	output logic             line_circuit_std,
	output logic             chan_open,
	output logic             powered_up,
	output logic             line_signal_detect_n
);
	uls_if rif ();

	////////////////////////////////////////////////////////////////////
	// register file
	uls_apb_regs u_regs (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.rif     (rif),
		.irq     (irq)
	);

	////////////////////////////////////////////////////////////////////
	// sequencer state
	typedef struct packed {
		uls_state_t       st;
		logic [31:0]      tmr;	// 15 s supervision
		logic [31:0]      rsy;	// resync window
		logic [2:0]       cnt;	// superframe / validation count
		logic             tmr_on;
		logic             pwr;
		logic             act;
		logic             dea;
		logic             txen;
		logic             chan;
		logic             lsd_n;
		logic             di_next;	// deactivated follows error
		logic [3:0]       ind;
		logic [IRQ_W-1:0] ev;
		logic             cso;
		logic             saif;
	} uls_seq_t;
	uls_seq_t s, next_s;
	logic nt;	// network-terminal mode
	logic cmd_pup, cmd_ar, cmd_ac, cmd_pdn, cmd_res;

	// command decode and next state
	always_comb begin
		next_s = s;
		nt = rif.cfg[CFG_NT_BIT];
		cmd_pup = rif.cmd_stb && rif.cmd_code == CODE_PUP_DR;
		cmd_ar  = rif.cmd_stb && rif.cmd_code == CODE_AR;
		cmd_ac  = rif.cmd_stb && rif.cmd_code == CODE_AC;
		cmd_pdn = rif.cmd_stb && (rif.cmd_code == CODE_PDN
			|| rif.cmd_code == CODE_DI);
		cmd_res = rif.cmd_stb && rif.cmd_code == CODE_RES;
		next_s.ev = '0;
		next_s.cso = rif.cfg[CFG_CSO_BIT];
		next_s.saif = rif.cfg[CFG_SAIF_BIT];
		// supervision timer
		if (s.tmr_on)
			next_s.tmr = s.tmr + 32'h00000001;
		// error indication is followed by deactivated next cycle
		if (s.di_next) begin
			next_s.di_next = 1'b0;
			next_s.ind = CODE_DI;
			next_s.ev[IRQ_DI] = 1'b1;
		end
		unique case (s.st)
			ST_RESET: begin
				// power control, valid only while deactivated
				if (cmd_pup && !s.pwr) begin
					next_s.pwr = 1'b1;
					next_s.lsd_n = 1'b1;
				end
				if (cmd_pdn)
					next_s.pwr = 1'b0;
				// wake-up tone from far end
				if (wake_tone) begin
					next_s.ind = nt ? CODE_PUP_DR : CODE_AR;
					next_s.ev[nt ? IRQ_LSD : IRQ_AP] = 1'b1;
					if (!s.pwr)
						next_s.lsd_n = 1'b0;
				end
				// activation only after the request, once powered up
				if (cmd_ar && s.pwr) begin
					next_s.st = ST_WAIT_SY;
					next_s.tmr = '0;
					next_s.tmr_on = 1'b1;
					next_s.txen = 1'b1;
					next_s.act = 1'b0;
					next_s.dea = 1'b1;
					next_s.lsd_n = 1'b1;
				end
			end
			ST_WAIT_SY: begin
				if (sf_sync) begin
					if (nt) begin
						// SL2 locked: pending, send act zero
						next_s.st = ST_NT_PEND;
						next_s.ind = CODE_AR;
						next_s.ev[IRQ_AP] = 1'b1;
						next_s.cnt = '0;
					end else if (rif.cfg[CFG_HALT_BIT]) begin
						next_s.st = ST_HALT;
						next_s.ind = CODE_AC;
						next_s.ev[IRQ_AI] = 1'b1;
					end else begin
						next_s.st = ST_ACTIVE;
						next_s.act = 1'b1;
						next_s.chan = 1'b1;
						next_s.tmr_on = 1'b0;
						next_s.ind = CODE_AC;
						next_s.ev[IRQ_AI] = 1'b1;
					end
				end
			end
			ST_HALT: begin
				// act held zero until host confirms
				if (cmd_ac) begin
					next_s.st = ST_ACTIVE;
					next_s.act = 1'b1;
					next_s.chan = 1'b1;
					next_s.tmr_on = 1'b0;
				end
			end
			ST_NT_PEND: begin
				if (cmd_ac)
					next_s.act = 1'b1;
				// three act-one superframes complete activation
				if (sf_tick) begin
					if (rx_act && s.act) begin
						next_s.cnt = s.cnt + 3'h1;
						if (s.cnt == 3'(VALIDATE_COUNT - 1)) begin
							next_s.st = ST_ACTIVE;
							next_s.chan = 1'b1;
							next_s.tmr_on = 1'b0;
							next_s.ind = CODE_AC;
							next_s.ev[IRQ_AI] = 1'b1;
							next_s.cnt = '0;
						end
					end else begin
						next_s.cnt = '0;
					end
				end
			end
			ST_ACTIVE: begin
				if (sync_lost) begin
					next_s.chan = 1'b0;
					next_s.ind = CODE_ERR;
					next_s.ev[IRQ_EI] = 1'b1;
					next_s.rsy = '0;
					next_s.st = ST_RESYNC;
				end else if (!nt && cmd_pup) begin
					next_s.st = ST_DEACT;
					next_s.dea = 1'b0;
					next_s.chan = 1'b0;	// no data once dea zero goes out
					next_s.cnt = '0;
				end else if (nt && sf_tick) begin
					// dea zero validated three times
					if (!rx_dea) begin
						next_s.cnt = s.cnt + 3'h1;
						if (s.cnt == 3'(VALIDATE_COUNT - 1)) begin
							next_s.st = ST_DP;
							next_s.ind = CODE_PUP_DR;
							next_s.ev[IRQ_DP] = 1'b1;
						end
					end else begin
						next_s.cnt = '0;
					end
				end
			end
			ST_DEACT: begin
				// four dea-zero superframes then silence
				if (sf_tick && s.txen) begin
					next_s.cnt = s.cnt + 3'h1;
					if (s.cnt == 3'(DEA_SF_COUNT - 1))
						next_s.txen = 1'b0;
				end
				if (!s.txen && !sig_present) begin
					next_s.st = ST_RESET;
					next_s.chan = 1'b0;
					next_s.act = 1'b0;
					next_s.dea = 1'b1;
					next_s.ind = CODE_DI;
					next_s.ev[IRQ_DI] = 1'b1;
				end
			end
			ST_DP: begin
				next_s.chan = 1'b0;
				if (!sig_present) begin
					next_s.st = ST_RESET;
					next_s.txen = 1'b0;
					next_s.act = 1'b0;
					next_s.ind = CODE_DI;
					next_s.ev[IRQ_DI] = 1'b1;
				end
			end
			ST_RESYNC: begin
				next_s.rsy = s.rsy + 32'h00000001;
				if (sf_sync && sig_present) begin
					next_s.st = ST_ACTIVE;
					next_s.chan = 1'b1;
					next_s.ind = CODE_AC;
				end else if (!sig_present
					|| 64'(s.rsy) >= RESYNC_LIM - 1) begin
					next_s.st = ST_FAULT;
				end
			end
			ST_FAULT: begin
				// full reset before any new attempt
				next_s.st = ST_RESET;
				next_s.txen = 1'b0;
				next_s.act = 1'b0;
				next_s.dea = 1'b1;
				next_s.chan = 1'b0;
				next_s.tmr_on = 1'b0;
				next_s.cnt = '0;
				next_s.ind = CODE_DI;
				next_s.ev[IRQ_DI] = 1'b1;
			end
			default: next_s.st = ST_RESET;
		endcase
		// activation timeout: error now, deactivated next
		if (s.tmr_on && 64'(s.tmr) >= TIMEOUT_CYC - 1) begin
			next_s.st = ST_RESET;
			next_s.tmr_on = 1'b0;
			next_s.txen = 1'b0;
			next_s.act = 1'b0;
			next_s.dea = 1'b1;
			next_s.chan = 1'b0;
			next_s.cnt = '0;
			next_s.ind = CODE_ERR;
			next_s.ev = '0;
			next_s.ev[IRQ_EI] = 1'b1;
			next_s.di_next = 1'b1;
		end
		// reset command returns sequencer to receive reset
		if (cmd_res) begin
			next_s.st = ST_RESET;
			next_s.tmr_on = 1'b0;
			next_s.txen = 1'b0;
			next_s.act = 1'b0;
			next_s.chan = 1'b0;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{st: ST_RESET, tmr: '0, rsy: '0, cnt: '0,
				tmr_on: 1'b0, pwr: 1'b0, act: 1'b0, dea: 1'b1,
				txen: 1'b0, chan: 1'b0, lsd_n: 1'b1, di_next: 1'b0,
				ind: CMD_RESET, ev: '0, cso: 1'b0, saif: 1'b1};
		end else begin
			s <= next_s;
		end
	end

	assign rif.ind_code         = s.ind;
	assign rif.events           = s.ev;
	assign tx_enable            = s.txen;
	assign tx_act               = s.act;
	assign tx_dea               = s.dea;
	assign tx_cso               = s.cso;
	assign line_circuit_std     = s.saif;
	assign chan_open            = s.chan;
	assign powered_up           = s.pwr;
	assign line_signal_detect_n = s.lsd_n;
endmodule // uls_sequencer

// file: hdl/uls_pkg.sv
// Purpose: shared constants and types of the loop activation sequencer
// Assumes: 125 MHz pclk, APB register access with 32-bit data
// Notes:   command and indication codes share one 4-bit coding
package uls_pkg;
	// clock and timing
	localparam int unsigned CLK_MHZ          = 125;
	localparam int unsigned ACT_TIMEOUT_S    = 15;
	localparam int unsigned RESYNC_MS        = 480;
	localparam longint unsigned ACT_TIMEOUT_CYC =
		longint'(ACT_TIMEOUT_S) * 1000000 * CLK_MHZ;
	localparam longint unsigned RESYNC_CYC =
		longint'(RESYNC_MS) * 1000 * CLK_MHZ;
	localparam int unsigned DEA_SF_COUNT     = 4;
	localparam int unsigned VALIDATE_COUNT   = 3;
	// register byte offsets
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_IND    = 8'h04;
	localparam logic [7:0] OFS_CFG    = 8'h08;
	localparam logic [7:0] OFS_STAT   = 8'h0c;
	localparam logic [7:0] OFS_MASK   = 8'h10;
	localparam logic [7:0] OFS_LINE   = 8'h14;
	// configuration field positions
	localparam int unsigned CFG_NT_BIT    = 0;
	localparam int unsigned CFG_HALT_BIT  = 1;
	localparam int unsigned CFG_SAIF_BIT  = 2;
	localparam int unsigned CFG_CSO_BIT   = 3;
	localparam logic [3:0]  CFG_RESET     = 4'h4;
	localparam logic [3:0]  CMD_RESET     = 4'hf;
	// activation command and indication codes
	localparam logic [3:0] CODE_PUP_DR = 4'h0;
	localparam logic [3:0] CODE_RES    = 4'h1;
	localparam logic [3:0] CODE_ERR    = 4'h4;
	localparam logic [3:0] CODE_PDN    = 4'h5;
	localparam logic [3:0] CODE_SYNC   = 4'h6;
	localparam logic [3:0] CODE_AR     = 4'h8;
	localparam logic [3:0] CODE_AC     = 4'hc;
	localparam logic [3:0] CODE_DI     = 4'hf;
	// interrupt status bit positions
	localparam int unsigned IRQ_W     = 6;
	localparam int unsigned IRQ_LSD   = 0;
	localparam int unsigned IRQ_AP    = 1;
	localparam int unsigned IRQ_AI    = 2;
	localparam int unsigned IRQ_EI    = 3;
	localparam int unsigned IRQ_DI    = 4;
	localparam int unsigned IRQ_DP    = 5;
	// sequencer states
	typedef enum logic [8:0] {
		ST_RESET   = 9'h001,
		ST_WAIT_SY = 9'h002,
		ST_HALT    = 9'h004,
		ST_ACTIVE  = 9'h008,
		ST_NT_PEND = 9'h010,
		ST_DEACT   = 9'h020,
		ST_RESYNC  = 9'h040,
		ST_FAULT   = 9'h080,
		ST_DP      = 9'h100
	} uls_state_t;
endpackage

// file: hdl/uls_if.sv
`timescale 1ns/100ps
// Purpose: bundle of decoded register fields between bus slave and core
// Assumes: single pclk domain
// Notes:   the slave drives controls, the sequencer drives status
interface uls_if;
	logic       cmd_stb;	// one-cycle pulse on command write
	logic [3:0] cmd_code;	// written command code
	logic [3:0] cfg;	// configuration bits
	logic [3:0] ind_code;	// current indication code
	logic [5:0] events;	// one-cycle event pulses
	modport slave (output cmd_stb, cmd_code, cfg, input ind_code, events);
	modport core  (input cmd_stb, cmd_code, cfg, output ind_code, events);
endinterface // uls_if

// file: hdl/uls_apb_regs.sv
`timescale 1ns/100ps
// Purpose: APB slave holding command, config, status and mask registers
// Assumes: APB with one wait state per access, aligned word accesses
// Notes:   status bits are write-one-to-clear, a new event wins
module uls_apb_regs
	import uls_pkg::*;
(
	// bus
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// core side
	uls_if.slave             rif,
	output logic             irq
);
	typedef struct packed {
		logic [3:0]        cmd;
		logic [3:0]        cfg;
		logic [IRQ_W-1:0]  stat;
		logic [IRQ_W-1:0]  mask;
		logic              stb;
		logic [31:0]       rdata;
		logic              rdy;
		logic              err;
		logic              irq;
	} uls_reg_t;
	uls_reg_t r, next_r;
	logic acc;	// access phase

	// register next-state logic
	always_comb begin
		next_r = r;
		acc = psel & penable & ~r.rdy;
		next_r.rdy = acc;
		next_r.err = 1'b0;
		next_r.stb = 1'b0;
		// events set, writes clear
		next_r.stat = r.stat | rif.events;
		if (acc) begin
			unique case (paddr)
				OFS_CMD: begin
					if (pwrite) begin
						next_r.cmd = pwdata[3:0];
						next_r.stb = 1'b1;
					end
					next_r.rdata = {28'h0000000, r.cmd};
				end
				OFS_IND:  next_r.rdata = {28'h0000000, rif.ind_code};
				OFS_CFG: begin
					if (pwrite)
						next_r.cfg = pwdata[3:0];
					next_r.rdata = {28'h0000000, r.cfg};
				end
				OFS_STAT: begin
					if (pwrite)
						next_r.stat = (r.stat & ~pwdata[IRQ_W-1:0])
							| rif.events;
					next_r.rdata = {26'h0, r.stat};
				end
				OFS_MASK: begin
					if (pwrite)
						next_r.mask = pwdata[IRQ_W-1:0];
					next_r.rdata = {26'h0, r.mask};
				end
				default: begin
					// unmapped address answers with an error
					next_r.err   = 1'b1;
					next_r.rdata = 32'h00000000;
				end
			endcase
		end
		// deactivation or failure restores the command register
		if (rif.events[IRQ_DI])
			next_r.cmd = CMD_RESET;
		next_r.irq = |(next_r.stat & next_r.mask);
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{cmd: CMD_RESET, cfg: CFG_RESET, stat: '0, mask: '0,
				stb: 1'b0, rdata: 32'h00000000, rdy: 1'b0, err: 1'b0,
				irq: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign prdata       = r.rdata;
	assign pready       = r.rdy;
	assign pslverr      = r.err;
	assign irq          = r.irq;
	assign rif.cmd_stb  = r.stb;
	assign rif.cmd_code = r.cmd;
	assign rif.cfg      = r.cfg;
endmodule // uls_apb_regs

// file: testbench/uls_far_end.sv
// Purpose: far-end transceiver model on the loop
// Assumes: bench requests arrive just after a pclk edge
// Notes:   maintenance bits are only valid at a superframe tick
`timescale 1ns/100ps
module uls_far_end (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// bench requests
	input  wire logic on,		// far end transmitting
	input  wire logic tone_req,	// send the wake-up tone
	input  wire logic sync_req,	// lock onto our signal
	input  wire logic lose_req,	// drop framing
	input  wire logic act_v,	// act bit to send
	input  wire logic dea_v,	// dea bit to send
	// line events toward the block
	output logic      wake_tone,
	output logic      sf_sync,
	output logic      sf_tick,
	output logic      rx_act,
	output logic      rx_dea,
	output logic      sync_lost,
	output logic      sig_present
);
	logic [3:0] gap;	// cycles into the superframe
	logic       last;	// superframe boundary
	assign last = on && (gap == 4'h9);
	////////////////////////////////////////////////////////////////////
	// superframes every ten cycles; bits toggle between ticks so that
	// a stale sample can never pass for a real one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap     <= 4'h0;
			sf_tick <= 1'b0;
			rx_act  <= 1'b0;
			rx_dea  <= 1'b1;
		end else begin
			gap     <= (gap == 4'h9) ? 4'h0 : gap + 4'h1;
			sf_tick <= last;
			rx_act  <= last ? act_v : ~rx_act;
			rx_dea  <= last ? dea_v : ~rx_dea;
		end
	end
	assign wake_tone   = tone_req;
	assign sf_sync     = sync_req && on;
	assign sync_lost   = lose_req;
	assign sig_present = on;
endmodule // uls_far_end

// file: testbench/uls_chk.sv
// Purpose: port-level checks of the loop sequencer
// Assumes: single pclk domain
// Notes:   bound to every sequencer instance
`timescale 1ns/100ps
module uls_chk (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// bus
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	// line
	input wire logic       wake_tone,
	input wire logic       sf_tick,
	input wire logic       sync_lost,
	input wire logic       tx_enable,
	input wire logic       tx_act,
	input wire logic       tx_dea,
	input wire logic       chan_open,
	input wire logic       powered_up,
	input wire logic       line_signal_detect_n
);
	logic [2:0] dea_sf;	// superframes sent with dea low
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////
	// count superframes while dea zero goes out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dea_sf <= 3'h0;
		else if (tx_dea)
			dea_sf <= 3'h0;
		else if (sf_tick && tx_enable && dea_sf != 3'h7)
			dea_sf <= dea_sf + 3'h1;
	end
	ans_next_a: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	unmapped_err_a: assert property
		(psel && penable && !pready && paddr == 8'h14 |=> pslverr)
		else $error("unmapped access not refused");
	chan_act_a: assert property (chan_open |-> tx_act && tx_enable)
		else $error("channels open without act");
	tone_pin_a: assert property
		(wake_tone && !powered_up |-> ##[1:3] !line_signal_detect_n)
		else $error("detect pin not pulled low");
	pin_down_a: assert property ($fell(line_signal_detect_n) |-> !powered_up)
		else $error("detect pin low while powered");
	loss_close_a: assert property (sync_lost && chan_open |-> ##[1:3] !chan_open)
		else $error("channels kept open on sync loss");
	dea_four_a: assert property ($fell(tx_enable) && !tx_dea |-> dea_sf == 3'h4)
		else $error("dea zero superframe count wrong");
	cover property ($rose(chan_open));
	cover property ($fell(tx_enable) && !tx_dea);
	cover property (pslverr);
endmodule // uls_chk
bind uls_sequencer uls_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .wake_tone(wake_tone), .sf_tick(sf_tick),
	.sync_lost(sync_lost), .tx_enable(tx_enable), .tx_act(tx_act),
	.tx_dea(tx_dea), .chan_open(chan_open), .powered_up(powered_up),
	.line_signal_detect_n(line_signal_detect_n));

// file: testbench/test_u_loop_activation_sequencer.sv
// Purpose: self-checking bench of the loop sequencer
// Assumes: short timeout and resync counts
// Notes:   bus results are checked against queued notes
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
	n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_u_loop_activation_sequencer
	import uls_pkg::*;
;
	typedef struct packed {
		logic [31:0] val;	// expected read data
		logic [31:0] msk;	// bits compared
		logic        err;	// expected pslverr
	} uls_exp_t;
	uls_exp_t    expq [$];	// notes for the monitor
	int          n_fail = 0, tests_run = 0;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, irq, tx_enable, tx_act, tx_dea, tx_cso;
	logic        line_circuit_std, chan_open, powered_up, lsd_n;
	logic        wake_tone, sf_sync, sf_tick, rx_act, rx_dea, sync_lost;
	logic        sig_present, on = 1'b0, act_v = 1'b0, dea_v = 1'b1;
	logic [2:0]  req = 3'h0;	// loss, sync and tone requests
	localparam logic [2:0] tone_rq = 3'h1, sync_rq = 3'h2, lose_rq = 3'h4;
	always #4 pclk = ~pclk;
	uls_sequencer #(.TIMEOUT_CYC(200), .RESYNC_LIM(50)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq),
		.wake_tone(wake_tone), .sf_sync(sf_sync), .sf_tick(sf_tick),
		.rx_act(rx_act), .rx_dea(rx_dea), .sync_lost(sync_lost),
		.sig_present(sig_present), .tx_enable(tx_enable), .tx_act(tx_act),
		.tx_dea(tx_dea), .tx_cso(tx_cso), .chan_open(chan_open),
		.line_circuit_std(line_circuit_std), .powered_up(powered_up),
		.line_signal_detect_n(lsd_n));
	uls_far_end u_far (.pclk(pclk), .presetn(presetn), .on(on),
		.tone_req(req[0]), .sync_req(req[1]), .lose_req(req[2]),
		.act_v(act_v),
		.dea_v(dea_v), .wake_tone(wake_tone), .sf_sync(sf_sync),
		.sf_tick(sf_tick), .rx_act(rx_act), .rx_dea(rx_dea),
		.sync_lost(sync_lost), .sig_present(sig_present));
	////////////////////////////////////////////////////////////////////
	// one apb transfer, noting its expected answer first
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] m, input logic e);
		expq.push_back('{wr ? 32'h0 : d, wr ? 32'h0 : m, e});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0, 1'b0);
	endtask
	task automatic ind(input logic [3:0] c);
		bus(1'b0, OFS_IND, {28'h0, c}, 32'hf, 1'b0);
	endtask
	task automatic cmd(input logic [3:0] c);
		wr(OFS_CMD, {28'h0, c});
		repeat (2) @(posedge pclk);
	endtask
	task automatic pulse(input logic [2:0] m);
		req <= m;
		@(posedge pclk);
		req <= 3'h0;
		@(posedge pclk);
	endtask
	// bounded wait for a level on a block output
	task automatic wait_lvl(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		`CHK("wait", v, s)
	endtask
	task automatic rst;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// monitor: compare each answer with the oldest note
	always @(posedge pclk) begin : mon
		uls_exp_t x;
		if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
			x = expq.pop_front();
			`CHK("prdata", x.val, prdata & x.msk)
			`CHK("pslverr", x.err, pslverr)
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		final_report();
	end
	initial begin
		void'($urandom(32'h744c88c3));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK("tx_dea", 1'b1, tx_dea)
		`CHK("circuit", 1'b1, line_circuit_std)
		bus(1'b0, OFS_CMD, 32'hf, 32'hf, 1'b0);
		bus(1'b0, OFS_CFG, 32'h4, 32'hf, 1'b0);
		bus(1'b0, OFS_LINE, 32'h0, 32'h0, 1'b1);
		r = $urandom;
		wr(OFS_MASK, r);
		bus(1'b0, OFS_MASK, r & 32'h3f, 32'h3f, 1'b0);
		// lt tone while powered down, masked
		wr(OFS_MASK, 32'h0);
		pulse(tone_rq);
		`CHK("lsd_n", 1'b0, lsd_n)
		`CHK("irq", 1'b0, irq)
		ind(CODE_AR);
		wr(OFS_MASK, 32'h3f);
		wait_lvl(irq, 1'b1);
		wr(OFS_STAT, 32'h3f);
		wait_lvl(irq, 1'b0);
		// lt activation, then loss of sync
		on <= 1'b1;
		cmd(CODE_PUP_DR);
		cmd(CODE_AR);
		pulse(sync_rq);
		wait_lvl(chan_open, 1'b1);
		`CHK("tx_act", 1'b1, tx_act)
		ind(CODE_AC);
		wr(OFS_STAT, 32'h3f);
		pulse(lose_rq);
		wait_lvl(irq, 1'b1);
		ind(CODE_ERR);
		wr(OFS_STAT, 32'h3f);
		wait_lvl(irq, 1'b1);
		ind(CODE_DI);
		// lt deactivation request
		cmd(CODE_PUP_DR);
		cmd(CODE_AR);
		pulse(sync_rq);
		wait_lvl(chan_open, 1'b1);
		cmd(CODE_PUP_DR);
		wait_lvl(tx_dea, 1'b0);
		`CHK("chan", 1'b0, chan_open)
		wait_lvl(tx_enable, 1'b0);
		wr(OFS_STAT, 32'h3f);
		on <= 1'b0;
		wait_lvl(irq, 1'b1);
		ind(CODE_DI);
		// timeout with no far end
		rst();
		wr(OFS_MASK, 32'h3f);
		cmd(CODE_PUP_DR);
		`CHK("pwr", 1'b1, powered_up)
		cmd(CODE_AR);
		wr(OFS_STAT, 32'h3f);
		wait_lvl(irq, 1'b1);
		bus(1'b0, OFS_STAT, 32'h18, 32'h18, 1'b0);
		ind(CODE_DI);
		bus(1'b0, OFS_CMD, 32'hf, 32'hf, 1'b0);
		// reset command while waiting for sync, power-down from receive reset
		cmd(CODE_AR);
		`CHK("tx_en", 1'b1, tx_enable)
		cmd(CODE_RES);
		`CHK("tx_en", 1'b0, tx_enable)
		cmd(CODE_PDN);
		`CHK("pwr", 1'b0, powered_up)
		// lt halt point
		rst();
		wr(OFS_CFG, 32'h6);
		wr(OFS_MASK, 32'h3f);
		on <= 1'b1;
		cmd(CODE_PUP_DR);
		cmd(CODE_AR);
		wr(OFS_STAT, 32'h3f);
		pulse(sync_rq);
		wait_lvl(irq, 1'b1);
		ind(CODE_AC);
		`CHK("tx_act", 1'b0, tx_act)
		cmd(CODE_AC);
		wait_lvl(tx_act, 1'b1);
		// nt tone, activation and deactivation
		rst();
		on <= 1'b0;
		wr(OFS_CFG, 32'h5);
		`CHK("cso", 1'b0, tx_cso)
		`CHK("circuit", 1'b1, line_circuit_std)
		wr(OFS_MASK, 32'h3f);
		pulse(tone_rq);
		`CHK("lsd_n", 1'b0, lsd_n)
		bus(1'b0, OFS_STAT, 32'h1, 32'h1, 1'b0);
		on <= 1'b1;
		cmd(CODE_PUP_DR);
		cmd(CODE_AR);
		wr(OFS_STAT, 32'h3f);
		pulse(sync_rq);
		wait_lvl(irq, 1'b1);
		ind(CODE_AR);
		`CHK("tx_act", 1'b0, tx_act)
		cmd(CODE_AC);
		act_v <= 1'b1;
		wait_lvl(chan_open, 1'b1);
		ind(CODE_AC);
		wr(OFS_STAT, 32'h3f);
		dea_v <= 1'b0;
		wait_lvl(irq, 1'b1);
		ind(CODE_PUP_DR);
		wr(OFS_STAT, 32'h3f);
		on <= 1'b0;
		wait_lvl(irq, 1'b1);
		ind(CODE_DI);
		`CHK("tx_en", 1'b0, tx_enable)
		final_report();
	end
endmodule // test_u_loop_activation_sequencer
